// [src/acp_clock_source.sv]
// Audio root clock source selection, reference clock setup, microphone clock
// divider and four-line PDM capture with a register port.
// Assumes synchronous inputs, a 50 MHz clock and a single-cycle register master.
`timescale 1ns/1ps
module acp_clock_source #(
    parameter int LINES = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire acp_pkg::acp_bus_s i_bus,
    output logic [7:0]             o_rdata,
    input  wire logic [LINES-1:0]  i_pdm_line,
    output logic                   o_mic_clk,
    output logic                   o_pdm_valid,
    output logic [2*LINES-1:0]     o_pdm_data,
    input  wire logic              i_pdm_ready,
    output acp_pkg::acp_src_e      o_root_src,
    output logic                   o_pll_en,
    output logic                   o_bclk_oe,
    output logic                   o_frame_sync_oe,
    output logic [11:0]            o_ratio,
    output logic [15:0]            o_ref_khz,
    output logic                   o_ref_by_ratio
);

    acp_pkg::acp_top_s s_q;
    acp_pkg::acp_top_s s_d;

    logic                 master;
    logic                 auto_on;
    logic                 pll_dis;
    logic [7:0]           lim;
    logic                 toggle;
    logic                 rise;
    logic                 fall;
    logic                 buf_ready;
    logic [2*LINES-1:0]   word;

    // ==========================================================
    // Decoded configuration
    assign master  = s_q.ctrl[acp_pkg::CTRL_MASTER_BIT];
    assign auto_on = !s_q.ctrl[acp_pkg::CTRL_AUTO_OFF_BIT];
    assign pll_dis = s_q.ctrl[acp_pkg::CTRL_PLL_DIS_BIT];

    // Half period follows both divider code and sample-rate family.
    assign lim = acp_pkg::acp_half_cycles(s_q.micdiv[acp_pkg::MICDIV_LSB +: 2],
                                          s_q.ctrl[acp_pkg::CTRL_FAM44_BIT]);

    // The divider halts while a captured word waits for buffer room.
    assign toggle = !s_q.pending && (s_q.cnt + 8'h01 >= lim);
    assign rise   = toggle && !s_q.mic_clk;
    assign fall   = toggle && s_q.mic_clk;

    // ==========================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.rdata = 8'h00;

        if (i_bus.wr) begin
            if (i_bus.addr == acp_pkg::OFF_CTRL) begin
                s_d.ctrl = i_bus.wdata;
            end else if (i_bus.addr == acp_pkg::OFF_SRC) begin
                s_d.src = i_bus.wdata & acp_pkg::SRC_RW_MASK;
            end else if (i_bus.addr == acp_pkg::OFF_MICDIV) begin
                s_d.micdiv = i_bus.wdata;
            end else if (i_bus.addr == acp_pkg::OFF_EDGE) begin
                s_d.edges = i_bus.wdata & acp_pkg::EDGE_RW_MASK;
            end
        end

        if (i_bus.rd) begin
            if (i_bus.addr == acp_pkg::OFF_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else if (i_bus.addr == acp_pkg::OFF_SRC) begin
                s_d.rdata = s_q.src;
            end else if (i_bus.addr == acp_pkg::OFF_MICDIV) begin
                s_d.rdata = s_q.micdiv;
            end else if (i_bus.addr == acp_pkg::OFF_EDGE) begin
                s_d.rdata = s_q.edges;
            end
        end

        s_d.pll_en = !(auto_on && pll_dis);

        if (!master && auto_on && pll_dis) begin
            if (s_q.src[acp_pkg::SRC_SEL_BIT]) begin
                s_d.root_src = acp_pkg::SRC_REF;
            end else begin
                s_d.root_src = acp_pkg::SRC_BCLK;
            end
        end else begin
            s_d.root_src = acp_pkg::SRC_PLL;
        end

        s_d.bclk_oe  = master;
        s_d.frame_sync_oe = master;

        // Ratio stands for master mode and for a reference root in slave mode.
        s_d.ratio = acp_pkg::acp_ratio(s_q.src[acp_pkg::SRC_RATIO_LSB +: 3]);

        s_d.ref_by_ratio = auto_on && s_q.src[acp_pkg::SRC_SPEC_BIT];
        if (auto_on && !s_q.src[acp_pkg::SRC_SPEC_BIT]) begin
            s_d.ref_khz = acp_pkg::acp_ref_khz(s_q.ctrl[acp_pkg::CTRL_FREQ_LSB +: 3]);
        end else begin
            s_d.ref_khz = 16'h0000;
        end

        if (s_q.pending) begin
            if (buf_ready) begin
                s_d.pending = 1'b0;
            end
        end else if (toggle) begin
            s_d.cnt     = 8'h00;
            s_d.mic_clk = !s_q.mic_clk;
            s_d.pending = rise;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q          <= '0;
            s_q.ctrl     <= acp_pkg::RST_CTRL;
            s_q.src      <= acp_pkg::RST_SRC;
            s_q.micdiv   <= acp_pkg::RST_MICDIV;
            s_q.edges    <= acp_pkg::RST_EDGE;
            s_q.root_src <= acp_pkg::SRC_PLL;
            s_q.pll_en   <= 1'b1;
            s_q.ratio    <= 12'h000;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Capture lanes, one per data line
    generate
        for (genvar g = 0; g < LINES; g++) begin : g_lane
            acp_pdm_lane u_lane (
                .i_clk      (i_clk),
                .i_rst_n    (i_rst_n),
                .i_line     (i_pdm_line[g]),
                .i_edge_sel (s_q.edges[7 - g]),
                .i_rise     (rise),
                .i_fall     (fall),
                .o_pair     (word[2*g +: 2])
            );
        end
    endgenerate

    // ==========================================================
    // Output buffer
    acp_pair_buf #(
        .W (2*LINES)
    ) u_buf (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_valid (s_q.pending),
        .i_data  (word),
        .o_ready (buf_ready),
        .o_valid (o_pdm_valid),
        .o_data  (o_pdm_data),
        .i_ready (i_pdm_ready)
    );

    assign o_rdata        = s_q.rdata;
    assign o_mic_clk      = s_q.mic_clk;
    assign o_root_src     = s_q.root_src;
    assign o_pll_en       = s_q.pll_en;
    assign o_bclk_oe      = s_q.bclk_oe;
    assign o_frame_sync_oe     = s_q.frame_sync_oe;
    assign o_ratio        = s_q.ratio;
    assign o_ref_khz      = s_q.ref_khz;
    assign o_ref_by_ratio = s_q.ref_by_ratio;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_src_write;
        i_bus.wr && i_bus.addr == acp_pkg::OFF_SRC;
    endsequence

    sequence s_src_read;
        i_bus.rd && i_bus.addr == acp_pkg::OFF_SRC;
    endsequence

    property p_root_sel;
        !master && auto_on && pll_dis |=>
            o_root_src == ($past(s_q.src[7]) ? acp_pkg::SRC_REF : acp_pkg::SRC_BCLK);
    endproperty
    a_root_sel: assert property (p_root_sel) else $error("Root source not from select bit.");

    property p_pll_off;
        auto_on && pll_dis |=> !o_pll_en;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("PLL stayed on in auto disable.");

    property p_reserved_zero;
        s_src_write ##[1:2] s_src_read |=> o_rdata[2:0] == 3'h0 && o_rdata[7:3] == $past(s_q.src[7:3]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero.");

    property p_ratio_map;
        s_src_write ##2 1'b1 |-> o_ratio == acp_pkg::acp_ratio($past(i_bus.wdata[5:3], 2));
    endproperty
    a_ratio_map: assert property (p_ratio_map) else $error("Ratio output wrong.");

    property p_freq_code;
        auto_on && !s_q.src[6] |=> o_ref_khz == acp_pkg::acp_ref_khz($past(s_q.ctrl[2:0])) && !o_ref_by_ratio;
    endproperty
    a_freq_code: assert property (p_freq_code) else $error("Reference frequency not from code.");

    property p_master_drive;
        ##1 o_bclk_oe == $past(master) && o_frame_sync_oe == $past(master);
    endproperty
    a_master_drive: assert property (p_master_drive) else $error("Clock drive disagrees with mode.");

    property p_half_period;
        // A divider write may shrink the limit under a running count, so that toggle is exempt.
        $changed(o_mic_clk) && $past(lim) == $past(lim, 2) |->
            $past(s_q.cnt) + 8'h01 >= $past(lim) && $past(s_q.cnt) < $past(lim);
    endproperty
    a_half_period: assert property (p_half_period) else $error("Microphone clock half period wrong.");

    property p_push_after_rise;
        $rose(o_mic_clk) |-> s_q.pending ##[1:3] !s_q.pending || !buf_ready;
    endproperty
    a_push_after_rise: assert property (p_push_after_rise) else $error("Captured word not offered.");

endmodule : acp_clock_source

// [inc/acp_pkg.sv]
// Shared constants, types and lookup functions of the audio clock source block.
// Assumes a 50 MHz system clock and a byte-wide register port.
package acp_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 50000000;

    // ==========================================================
    // Register offsets and reset values
    localparam logic [7:0] OFF_CTRL    = 8'h13;
    localparam logic [7:0] OFF_SRC     = 8'h16;
    localparam logic [7:0] OFF_MICDIV  = 8'h1f;
    localparam logic [7:0] OFF_EDGE    = 8'h20;
    localparam logic [7:0] RST_CTRL    = 8'h02;
    localparam logic [7:0] RST_SRC     = 8'h10;
    localparam logic [7:0] RST_MICDIV  = 8'h40;
    localparam logic [7:0] RST_EDGE    = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CTRL_MASTER_BIT  = 7;
    localparam int CTRL_AUTO_OFF_BIT = 6;
    localparam int CTRL_PLL_DIS_BIT = 5;
    localparam int CTRL_FAM44_BIT   = 3;
    localparam int CTRL_FREQ_LSB    = 0;
    localparam int SRC_SEL_BIT      = 7;
    localparam int SRC_SPEC_BIT     = 6;
    localparam int SRC_RATIO_LSB    = 3;
    localparam int MICDIV_LSB       = 0;
    localparam int EDGE_LSB         = 4;
    localparam logic [7:0] SRC_RW_MASK  = 8'hf8;
    localparam logic [7:0] EDGE_RW_MASK = 8'hf0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acp_bus_s;

    typedef enum logic [2:0] {
        SRC_PLL  = 3'b001,
        SRC_BCLK = 3'b010,
        SRC_REF  = 3'b100
    } acp_src_e;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  src;
        logic [7:0]  micdiv;
        logic [7:0]  edges;
        logic [7:0]  rdata;
        acp_src_e    root_src;
        logic        pll_en;
        logic        bclk_oe;
        logic        frame_sync_oe;
        logic [11:0] ratio;
        logic [15:0] ref_khz;
        logic        ref_by_ratio;
        logic [7:0]  cnt;
        logic        mic_clk;
        logic        pending;
    } acp_top_s;

    // ==========================================================
    // Lookups
    function automatic logic [11:0] acp_ratio(input logic [2:0] code);
        logic [11:0] r;
        case (code)
            3'h0: r = 12'h040;
            3'h1: r = 12'h100;
            3'h2: r = 12'h180;
            3'h3: r = 12'h200;
            3'h4: r = 12'h300;
            3'h5: r = 12'h400;
            3'h6: r = 12'h600;
            default: r = 12'h900;
        endcase
        return r;
    endfunction : acp_ratio

    function automatic logic [15:0] acp_ref_khz(input logic [2:0] code);
        logic [15:0] k;
        case (code)
            3'h0: k = 16'h2ee0;
            3'h1: k = 16'h3000;
            3'h2: k = 16'h32c8;
            3'h3: k = 16'h3e80;
            3'h4: k = 16'h4b00;
            3'h5: k = 16'h4ce0;
            3'h6: k = 16'h5dc0;
            default: k = 16'h6000;
        endcase
        return k;
    endfunction : acp_ref_khz

    // Half period of the microphone clock in system cycles, rounded down.
    function automatic logic [7:0] acp_half_cycles(input logic [1:0] div, input logic fam44);
        int f;
        int h;
        case (div)
            2'h0: f = fam44 ? 2822400 : 3072000;
            2'h1: f = fam44 ? 1411200 : 1536000;
            2'h2: f = fam44 ? 705600 : 768000;
            default: f = fam44 ? 5644800 : 6144000;
        endcase
        h = CLK_HZ / (2 * f);
        if (h < 1) begin
            h = 1;
        end
        return h[7:0];
    endfunction : acp_half_cycles

endpackage : acp_pkg

// [src/acp_pdm_lane.sv]
// One microphone data line: latches the two channels on opposite clock edges.
// Assumes rise and fall strobes are one cycle long and line data is synchronous.
`timescale 1ns/1ps
module acp_pdm_lane (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_line,
    input  wire logic       i_edge_sel,
    input  wire logic       i_rise,
    input  wire logic       i_fall,
    output logic [1:0]      o_pair
);
    typedef struct packed {
        logic odd_ch;
        logic even_ch;
    } acp_lane_s;

    acp_lane_s s_q;
    acp_lane_s s_d;

    // ==========================================================
    // Edge selection
    // The microphones drive each channel valid at its own edge.
    always_comb begin
        s_d = s_q;
        if (i_fall) begin
            if (!i_edge_sel) begin
                s_d.odd_ch = i_line;
            end else begin
                s_d.even_ch = i_line;
            end
        end else if (i_rise) begin
            if (!i_edge_sel) begin
                s_d.even_ch = i_line;
            end else begin
                s_d.odd_ch = i_line;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_pair = {s_q.even_ch, s_q.odd_ch};

    // ==========================================================
    // Checks
    property p_fall_latch;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_fall |=> o_pair[$past(i_edge_sel)] == $past(i_line);
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("Fall edge latched wrong channel.");

    property p_rise_latch;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rise |=> o_pair[!$past(i_edge_sel)] == $past(i_line);
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("Rise edge latched wrong channel.");

endmodule : acp_pdm_lane

// [src/acp_pair_buf.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall for any time; outputs come from flip-flops.
`timescale 1ns/1ps
module acp_pair_buf #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    output logic              o_valid,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready
);
    typedef struct packed {
        logic         out_v;
        logic [W-1:0] out_d;
        logic         spare_v;
        logic [W-1:0] spare_d;
    } acp_buf_s;

    acp_buf_s s_q;
    acp_buf_s s_d;
    logic     push;

    // ==========================================================
    // Entry movement
    always_comb begin
        s_d  = s_q;
        push = i_valid && !s_q.spare_v;
        if (!s_q.out_v || i_ready) begin
            if (s_q.spare_v) begin
                s_d.out_d   = s_q.spare_d;
                s_d.out_v   = 1'b1;
                s_d.spare_v = 1'b0;
            end else begin
                s_d.out_d = i_data;
                s_d.out_v = push;
            end
        end else if (push) begin
            s_d.spare_d = i_data;
            s_d.spare_v = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_ready = !s_q.spare_v;
    assign o_valid = s_q.out_v;
    assign o_data  = s_q.out_d;

    property p_hold_stalled;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_valid && !i_ready |=> o_valid && $stable(o_data);
    endproperty
    a_hold_stalled: assert property (p_hold_stalled) else $error("Stalled word changed or vanished.");

endmodule : acp_pair_buf

// [verification/acp_mic_model.sv]
// Pairs of PDM microphones on four shared data lines, one pair per line.
// Assumes the capture side samples a line just before it toggles the clock.
`timescale 1ns/1ps
module acp_mic_model (
    input  wire logic       i_mic_clk,
    input  wire logic [7:0] i_ch_bits,
    input  wire logic [3:0] i_edge_sel,
    output logic [3:0]      o_line
);

    // ==========================================================
    // Line drive
    // Each half period belongs to the microphone whose sample is latched at the
    // edge that ends it, so the line is never left to float between them.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_line[k] = (i_mic_clk ^ i_edge_sel[k]) ? i_ch_bits[2*k] : i_ch_bits[2*k+1];
        end
    end

endmodule : acp_mic_model

// [verification/audio_clock_source_and_pdm_capture_tb.sv]
// Self-checking bench of the clock source and PDM capture block.
// Assumes the microphone model on the data lines and a 50 MHz clock.
`timescale 1ns/1ps
module audio_clock_source_and_pdm_capture_tb;
    logic              clk;
    logic              rst_n;
    acp_pkg::acp_bus_s bus;
    logic [7:0]        rdata;
    logic [3:0]        line;
    logic              mic_clk;
    logic              pdm_valid;
    logic [7:0]        pdm_data;
    logic              pdm_ready;
    acp_pkg::acp_src_e root_src;
    logic              pll_en;
    logic              bclk_oe;
    logic              frame_sync_oe;
    logic [11:0]       ratio;
    logic [15:0]       ref_khz;
    logic              ref_by_ratio;
    logic [7:0]        ch_bits;
    logic [3:0]        mic_sel;
    int                err_total;
    int                total_checks;

    localparam logic [15:0] RATIO_TAB [8] = '{16'h0040, 16'h0100, 16'h0180, 16'h0200,
                                              16'h0300, 16'h0400, 16'h0600, 16'h0900};
    localparam logic [15:0] KHZ_TAB [8]   = '{16'h2ee0, 16'h3000, 16'h32c8, 16'h3e80,
                                              16'h4b00, 16'h4ce0, 16'h5dc0, 16'h6000};
    localparam logic [15:0] HALF_TAB [8]  = '{16'h0008, 16'h0010, 16'h0020, 16'h0004,
                                              16'h0008, 16'h0011, 16'h0023, 16'h0004};

    // ==========================================================
    // Clock and instances
    always #10 clk = ~clk;

    acp_clock_source dut (
        .i_clk          (clk),
        .i_rst_n        (rst_n),
        .i_bus          (bus),
        .o_rdata        (rdata),
        .i_pdm_line     (line),
        .o_mic_clk      (mic_clk),
        .o_pdm_valid    (pdm_valid),
        .o_pdm_data     (pdm_data),
        .i_pdm_ready    (pdm_ready),
        .o_root_src     (root_src),
        .o_pll_en       (pll_en),
        .o_bclk_oe      (bclk_oe),
        .o_frame_sync_oe     (frame_sync_oe),
        .o_ratio        (ratio),
        .o_ref_khz      (ref_khz),
        .o_ref_by_ratio (ref_by_ratio)
    );

    acp_mic_model mics (
        .i_mic_clk  (mic_clk),
        .i_ch_bits  (ch_bits),
        .i_edge_sel (mic_sel),
        .o_line     (line)
    );

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        check(what, {8'h00, rdata}, {8'h00, e});
    endtask : rd_chk

    // Derived outputs trail the registers by one cycle.
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic wait_mic(input logic lvl, output int n);
        n = 0;
        while (mic_clk !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_mic

    task automatic get_word(output logic [7:0] w);
        int g;
        g = 0;
        @(negedge clk);
        while (pdm_valid !== 1'b1 && g < 300) begin
            @(negedge clk);
            g++;
        end
        check("word offered", {15'h0000, pdm_valid}, 16'h0001);
        w = pdm_data;
        @(posedge clk);
    endtask : get_word

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk("ctrl reset", acp_pkg::OFF_CTRL, 8'h02);
        rd_chk("src reset", acp_pkg::OFF_SRC, 8'h10);
        rd_chk("micdiv reset", acp_pkg::OFF_MICDIV, 8'h40);
        rd_chk("edge reset", acp_pkg::OFF_EDGE, 8'h00);
        wr(acp_pkg::OFF_EDGE, 8'hff);
        wr(acp_pkg::OFF_MICDIV, 8'hff);
        wr(8'h14, 8'hff);
        wr(acp_pkg::OFF_SRC, 8'hff);
        rd_chk("src reserved", acp_pkg::OFF_SRC, 8'hf8);
        rd_chk("edge reserved", acp_pkg::OFF_EDGE, 8'hf0);
        rd_chk("micdiv storage", acp_pkg::OFF_MICDIV, 8'hff);
        rd_chk("unmapped", 8'h14, 8'h00);
        wr(acp_pkg::OFF_SRC, 8'h10);
        wr(acp_pkg::OFF_EDGE, 8'h00);
        wr(acp_pkg::OFF_MICDIV, 8'h40);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_ratio_ref();
        for (int c = 0; c < 8; c++) begin
            wr(acp_pkg::OFF_SRC, 8'(c << 3));
            wr(acp_pkg::OFF_CTRL, 8'(c));
            settle();
            check("ratio", {4'h0, ratio}, RATIO_TAB[c]);
            check("ref khz", ref_khz, KHZ_TAB[c]);
        end
        wr(acp_pkg::OFF_SRC, 8'h50);
        settle();
        check("by ratio", {15'h0000, ref_by_ratio}, 16'h0001);
        check("ref khz spec", ref_khz, 16'h0000);
        wr(acp_pkg::OFF_CTRL, 8'h42);
        settle();
        check("auto off by ratio", {15'h0000, ref_by_ratio}, 16'h0000);
        wr(acp_pkg::OFF_CTRL, 8'h02);
        wr(acp_pkg::OFF_SRC, 8'h10);
        $display("t_ratio_ref done");
    endtask : t_ratio_ref

    task automatic t_root();
        wr(acp_pkg::OFF_CTRL, 8'h20);
        settle();
        check("root bclk", {13'h0000, root_src}, 16'h0002);
        check("pll off", {15'h0000, pll_en}, 16'h0000);
        wr(acp_pkg::OFF_SRC, 8'h90);
        settle();
        check("root ref", {13'h0000, root_src}, 16'h0004);
        check("ref ratio", {4'h0, ratio}, 16'h0180);
        wr(acp_pkg::OFF_CTRL, 8'h00);
        settle();
        check("root pll", {13'h0000, root_src}, 16'h0001);
        check("pll on", {15'h0000, pll_en}, 16'h0001);
        check("slave oe", {14'h0000, bclk_oe, frame_sync_oe}, 16'h0000);
        wr(acp_pkg::OFF_CTRL, 8'h80);
        settle();
        check("master oe", {14'h0000, bclk_oe, frame_sync_oe}, 16'h0003);
        wr(acp_pkg::OFF_CTRL, 8'h02);
        wr(acp_pkg::OFF_SRC, 8'h10);
        $display("t_root done");
    endtask : t_root

    task automatic t_mic_clock();
        int n;
        for (int c = 0; c < 8; c++) begin
            wr(acp_pkg::OFF_CTRL, 8'(((c >> 2) << 3) | 2));
            wr(acp_pkg::OFF_MICDIV, 8'(8'h40 | (c & 3)));
            repeat (2) begin
                wait_mic(1'b1, n);
                wait_mic(1'b0, n);
            end
            // The low half is timed: the capture cycle after a rise stretches the high half.
            wait_mic(1'b1, n);
            check("mic half period", 16'(n), HALF_TAB[c]);
        end
        wr(acp_pkg::OFF_CTRL, 8'h02);
        wr(acp_pkg::OFF_MICDIV, 8'h40);
        $display("t_mic_clock done");
    endtask : t_mic_clock

    task automatic t_capture();
        logic [7:0] w;
        logic [3:0] m;
        logic [3:0] r;
        logic [7:0] e;
        for (int c = 0; c < 6; c++) begin
            m = (c == 4) ? 4'hf : 4'h0;
            r = (c < 4) ? 4'(1 << c) : 4'hf;
            @(posedge clk);
            mic_sel <= m;
            wr(acp_pkg::OFF_EDGE, {r[0], r[1], r[2], r[3], 4'h0});
            for (int k = 0; k < 4; k++) begin
                e[2*k]   = (m[k] ^ r[k]) ? ch_bits[2*k+1] : ch_bits[2*k];
                e[2*k+1] = (m[k] ^ r[k]) ? ch_bits[2*k] : ch_bits[2*k+1];
            end
            repeat (4) get_word(w);
            check("pair order", {8'h00, w}, {8'h00, e});
        end
        @(posedge clk);
        mic_sel <= 4'h0;
        wr(acp_pkg::OFF_EDGE, 8'h00);
        $display("t_capture done");
    endtask : t_capture

    task automatic t_stall();
        int n;
        logic [7:0] w;
        repeat (3) get_word(w);
        @(posedge clk);
        pdm_ready <= 1'b0;
        repeat (100) @(posedge clk);
        @(negedge clk);
        check("stall valid", {15'h0000, pdm_valid}, 16'h0001);
        wait_mic(~mic_clk, n);
        check("clock halted", 16'(n), 16'h012c);
        check("stall data", {8'h00, pdm_data}, 16'h0096);
        @(posedge clk);
        pdm_ready <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            get_word(w);
            check("drained word", {8'h00, w}, 16'h0096);
        end
        $display("t_stall done");
    endtask : t_stall

    // ==========================================================
    // Run control
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #600000;
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        clk          = 1'b0;
        rst_n        = 1'b0;
        bus          = '0;
        pdm_ready    = 1'b1;
        ch_bits      = 8'h96;
        mic_sel      = 4'h0;
        err_total    = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("reset mic clk", {15'h0000, mic_clk}, 16'h0000);
        check("reset valid", {15'h0000, pdm_valid}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check("reset ratio", {4'h0, ratio}, 16'h0180);
        check("reset ref khz", ref_khz, 16'h32c8);
        check("reset root", {13'h0000, root_src}, 16'h0001);
        t_regs();
        t_ratio_ref();
        t_root();
        t_mic_clock();
        t_capture();
        t_stall();
        tally_and_finish();
    end

endmodule : audio_clock_source_and_pdm_capture_tb
